// *** logic/acc_edge.sv ***
// Per-comparator synchroniser and event detector
`timescale 1ns/10ps
module acc_edge (
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              raw,
    input  wire logic              on,
    input  wire acc_pkg::acc_edge_t edge_sel,
    output logic                   level,
    output logic                   event_p
);
    logic s1_q, s1_d;
    logic s2_q, s2_d;
    logic prev_q, prev_d;
    logic ev;

    always_comb begin
        s1_d   = raw;
        s2_d   = s1_q;
        prev_d = s2_q;
        ev     = 1'b0;
        unique case (edge_sel)
            acc_pkg::EDGE_TOGGLE:  ev = s2_q ^ prev_q;
            acc_pkg::EDGE_RSVD:    ev = 1'b0;
            acc_pkg::EDGE_FALLING: ev = prev_q & ~s2_q;
            acc_pkg::EDGE_RISING:  ev = ~prev_q & s2_q;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s1_q   <= 1'b0;
            s2_q   <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            s1_q   <= s1_d;
            s2_q   <= s2_d;
            prev_q <= prev_d;
        end
    end

    // Reserved code 01 raises nothing; disabled comparator raises nothing
    assign event_p = ev & on;
    assign level   = s2_q;
endmodule

// *** logic/acc_pkg.sv ***
// Constants and types for the analog comparator control block
package acc_pkg;
    localparam int N_CMP = 3;
    localparam int AW    = 4;
    localparam int DW    = 8;

    // Register word addresses
    localparam logic [3:0] ADDR_CTRL1  = 4'h0;
    localparam logic [3:0] ADDR_CTRL2  = 4'h1;
    localparam logic [3:0] ADDR_CTRL3  = 4'h2;
    localparam logic [3:0] ADDR_ECTRL1 = 4'h3;
    localparam logic [3:0] ADDR_ECTRL2 = 4'h4;
    localparam logic [3:0] ADDR_ECTRL3 = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h7;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h8;

    // Control register fields
    localparam int CTL_ON    = 7;
    localparam int CTL_IRQ   = 6;
    localparam int CTL_SEL_H = 5;
    localparam int CTL_SEL_L = 4;
    localparam int CTL_ALT   = 3;
    localparam int CTL_NEG_H = 2;

    // Extended control fields
    localparam int EXT_INV   = 5;
    localparam int EXT_OE    = 4;
    localparam int EXT_CAP   = 3;
    localparam int EXT_HYS_H = 2;

    // Shared status layout: flags 7..5, results 3..1
    localparam int ST_FLAG_LO = 5;
    localparam int ST_RES_LO  = 1;

    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] CTL_WMASK1 = 8'hF7;
    localparam logic [7:0] CTL_WMASK3 = 8'hFF;
    localparam logic [7:0] EXT_WMASK  = 8'h3F;
    localparam logic [7:0] ZERO8      = 8'h00;

    typedef enum logic [1:0] {
        EDGE_TOGGLE  = 2'b00,
        EDGE_RSVD    = 2'b01,
        EDGE_FALLING = 2'b10,
        EDGE_RISING  = 2'b11
    } acc_edge_t;

    typedef enum logic [2:0] {
        NEG_REF_D640 = 3'b000,
        NEG_REF_D320 = 3'b001,
        NEG_REF_D213 = 3'b010,
        NEG_REF_D160 = 3'b011,
        NEG_BANDGAP  = 3'b100,
        NEG_DAC      = 3'b101,
        NEG_OWN_PIN  = 3'b110,
        NEG_SHARED   = 3'b111
    } acc_neg_t;

    typedef struct packed {
        logic       on;
        logic       irq_allow;
        acc_edge_t  edge_sel;
        logic       alt_pin_on;
        acc_neg_t   neg_sel;
    } acc_ctrl_t;

    typedef struct packed {
        logic [1:0] rsvd;
        logic       out_invert;
        logic       out_pin_on;
        logic       capture_route;
        logic [2:0] hyst_sel;
    } acc_ext_t;

    typedef struct packed {
        logic            wr;
        logic            rd;
        logic [AW-1:0]   addr;
        logic [DW-1:0]   wdata;
    } acc_bus_t;
endpackage

// *** logic/acc_top.sv ***
// Register file, routing and interrupt logic for three comparators
`timescale 1ns/10ps
// Notes on behaviour
// - Bit 7 of each control register switches that comparator on.
// - Bit 6 lets that comparator's flag drive cmp_irq_req; irq is gated by ien_q alone.
// - Sensitivity 00 triggers on any output change; 01 is reserved.
// - Sensitivity 10 falling edge, 11 rising edge.
// - Codes 000..011 pick reference fractions /6.40 /3.20 /2.13 /1.60.
// - Code 100 routes bandgap, code 101 routes the DAC output.
// - Code 110 picks comparator 1 own pin, 111 the shared pin.
// - Comparators 2 and 3 decode alike, 110 being their own pin.
// - Bit 3 enables comparator 3 alternate pin; reserved for 1 and 2.
// - Three control registers plus one shared status of outputs and flags.
// - Extended: invert b5, pin enable b4, capture b3, hysteresis b2..0.
// - Output high when positive pin exceeds the selected negative input.
// - Flag set on selected event; cleared by vector acknowledge when bit 6 is set, or by writing one.
// - Comparator 1 capture bit routes its output to timer capture.
// - Invert bit inverts the comparator output.
module acc_top (
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  wire logic [acc_pkg::AW-1:0]    reg_addr,
    input  wire logic [acc_pkg::DW-1:0]    reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [acc_pkg::DW-1:0]    reg_rdata,
    input  wire logic [2:0]                cmp_raw,
    input  wire logic [2:0]                vector_ack,
    output logic      [2:0]                cmp_analog_on,
    output logic      [8:0]                cmp_neg_sel,
    output logic      [8:0]                cmp_hyst_sel,
    output logic      [2:0]                cmp_pin_out,
    output logic      [2:0]                cmp_pin_oe_n,
    output logic                           cmp3_alt_out,
    output logic                           cmp3_alt_oe_n,
    output logic                           capture_in,
    output logic      [2:0]                cmp_irq_req,
    output logic                           irq
);
    acc_pkg::acc_ctrl_t ctl_q [3];
    acc_pkg::acc_ctrl_t ctl_d [3];
    acc_pkg::acc_ext_t  ext_q [3];
    acc_pkg::acc_ext_t  ext_d [3];
    logic [2:0]         flag_q, flag_d;
    logic [2:0]         ien_q, ien_d;
    logic [7:0]         rdata_q, rdata_d;
    logic [2:0]         level, ev, res;
    logic [2:0]         out_q, out_d;
    logic               w1c_status;

    acc_pkg::acc_bus_t  bus;
    assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr,
                   wdata: reg_wdata};

    // Register layout and status packing are fixed to three comparators
    generate
        if (acc_pkg::N_CMP != 3) begin : gen_bad_count
            $error("acc_top serves exactly three comparators");
        end
    endgenerate

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gen_cmp
            acc_edge acc_edge_inst (
                .ref_clk  (ref_clk),
                .reset    (reset),
                .raw      (cmp_raw[g]),
                .on       (ctl_q[g].on),
                .edge_sel (ctl_q[g].edge_sel),
                .level    (level[g]),
                .event_p  (ev[g])
            );
            // Analog result is high when positive beats negative input
            assign res[g] = level[g] & ctl_q[g].on;
            assign cmp_analog_on[g] = ctl_q[g].on;
            // Codes map straight to the analog mux; 110 is own pin
            assign cmp_neg_sel[3*g +: 3] = ctl_q[g].neg_sel;
            assign cmp_hyst_sel[3*g +: 3] = ext_q[g].hyst_sel;
            assign out_d[g] = res[g] ^ ext_q[g].out_invert;
            assign cmp_pin_out[g]  = out_q[g];
            assign cmp_pin_oe_n[g] = ~ext_q[g].out_pin_on;
            assign cmp_irq_req[g] = flag_q[g] & ctl_q[g].irq_allow;
        end
    endgenerate

    // Alternate pin only on comparator 3
    assign cmp3_alt_out  = out_q[2];
    assign cmp3_alt_oe_n = ~ctl_q[2].alt_pin_on;
    // No path to the timer unless routing bit is set
    assign capture_in = ext_q[0].capture_route & out_q[0];
    assign irq = |(flag_q & ien_q);
    assign reg_rdata = rdata_q;

    assign w1c_status = bus.wr && (bus.addr == acc_pkg::ADDR_STATUS);

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ctl_d[i] = ctl_q[i];
            ext_d[i] = ext_q[i];
        end
        ien_d  = ien_q;
        flag_d = flag_q;
        if (bus.wr) begin
            unique case (bus.addr)
                acc_pkg::ADDR_CTRL1:
                    ctl_d[0] = bus.wdata & acc_pkg::CTL_WMASK1;
                acc_pkg::ADDR_CTRL2:
                    ctl_d[1] = bus.wdata & acc_pkg::CTL_WMASK1;
                acc_pkg::ADDR_CTRL3:
                    ctl_d[2] = bus.wdata & acc_pkg::CTL_WMASK3;
                acc_pkg::ADDR_ECTRL1:
                    ext_d[0] = bus.wdata & acc_pkg::EXT_WMASK;
                acc_pkg::ADDR_ECTRL2:
                    ext_d[1] = bus.wdata & acc_pkg::EXT_WMASK;
                acc_pkg::ADDR_ECTRL3:
                    ext_d[2] = bus.wdata & acc_pkg::EXT_WMASK;
                acc_pkg::ADDR_IRQ_EN:
                    ien_d = bus.wdata[2:0];
                default: ;
            endcase
        end
        // Clears first so a same-cycle event still sets the flag
        if (w1c_status)
            flag_d = flag_d & ~bus.wdata[acc_pkg::ST_FLAG_LO +: 3];
        if (bus.wr && bus.addr == acc_pkg::ADDR_IRQ_CLR)
            flag_d = flag_d & ~bus.wdata[2:0];
        flag_d = flag_d & ~(vector_ack & {ctl_q[2].irq_allow,
                  ctl_q[1].irq_allow, ctl_q[0].irq_allow});
        flag_d = flag_d | ev;
    end

    always_comb begin
        rdata_d = acc_pkg::ZERO8;
        if (bus.rd) begin
            unique case (bus.addr)
                acc_pkg::ADDR_CTRL1:  rdata_d = ctl_q[0];
                acc_pkg::ADDR_CTRL2:  rdata_d = ctl_q[1];
                acc_pkg::ADDR_CTRL3:  rdata_d = ctl_q[2];
                acc_pkg::ADDR_ECTRL1: rdata_d = ext_q[0];
                acc_pkg::ADDR_ECTRL2: rdata_d = ext_q[1];
                acc_pkg::ADDR_ECTRL3: rdata_d = ext_q[2];
                acc_pkg::ADDR_STATUS: begin
                    rdata_d[acc_pkg::ST_FLAG_LO +: 3] = flag_q;
                    rdata_d[acc_pkg::ST_RES_LO +: 3]  = res;
                end
                acc_pkg::ADDR_IRQ_EN: rdata_d = {5'h0, ien_q};
                default: rdata_d = acc_pkg::ZERO8;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < 3; i++) begin
                ctl_q[i] <= acc_pkg::CTL_RESET;
                ext_q[i] <= acc_pkg::CTL_RESET;
            end
            flag_q  <= 3'h0;
            ien_q   <= 3'h0;
            out_q   <= 3'h0;
            rdata_q <= acc_pkg::ZERO8;
        end else begin
            for (int i = 0; i < 3; i++) begin
                ctl_q[i] <= ctl_d[i];
                ext_q[i] <= ext_d[i];
            end
            flag_q  <= flag_d;
            ien_q   <= ien_d;
            out_q   <= out_d;
            rdata_q <= rdata_d;
        end
    end

    // Checks
    property p_flag_set;
        @(posedge ref_clk) disable iff (reset)
        ev[0] |=> flag_q[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_off_quiet;
        @(posedge ref_clk) disable iff (reset)
        !ctl_q[1].on |-> !ev[1];
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("event while off");

    property p_rise;
        @(posedge ref_clk) disable iff (reset)
        (ctl_q[0].on && ctl_q[0].edge_sel == acc_pkg::EDGE_RISING
         && ev[0]) |-> level[0] && !$past(level[0]);
    endproperty
    a_rise: assert property (p_rise) else $error("bad rising event");

    property p_fall;
        @(posedge ref_clk) disable iff (reset)
        (ctl_q[2].edge_sel == acc_pkg::EDGE_FALLING && ev[2])
        |-> !level[2] && $past(level[2]);
    endproperty
    a_fall: assert property (p_fall) else $error("bad falling event");

    property p_toggle;
        @(posedge ref_clk) disable iff (reset)
        (ctl_q[1].on && ctl_q[1].edge_sel == acc_pkg::EDGE_TOGGLE
         && $changed(level[1]) && $stable(ctl_q[1])) |-> ev[1];
    endproperty
    a_toggle: assert property (p_toggle) else $error("toggle missed");

    property p_rsvd;
        @(posedge ref_clk) disable iff (reset)
        ctl_q[0].edge_sel == acc_pkg::EDGE_RSVD |-> !ev[0];
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved code fired");

    property p_w1c;
        @(posedge ref_clk) disable iff (reset)
        (w1c_status && bus.wdata[acc_pkg::ST_FLAG_LO] && !ev[0])
        |=> !flag_q[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared");

    property p_irq_gate;
        @(posedge ref_clk) disable iff (reset)
        cmp_irq_req[2] |-> flag_q[2] && ctl_q[2].irq_allow;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq leak");

    property p_invert;
        @(posedge ref_clk) disable iff (reset)
        $stable(ext_q[0]) && $stable(res[0]) |=>
        cmp_pin_out[0] == ($past(res[0]) ^ $past(ext_q[0].out_invert));
    endproperty
    a_invert: assert property (p_invert) else $error("invert wrong");

    property p_cap;
        @(posedge ref_clk) disable iff (reset)
        !ext_q[0].capture_route |-> !capture_in;
    endproperty
    a_cap: assert property (p_cap) else $error("capture leak");

    property p_rd;
        @(posedge ref_clk) disable iff (reset)
        (bus.rd && bus.addr == acc_pkg::ADDR_CTRL3) |=>
        reg_rdata == $past(ctl_q[2]);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");

    c_rise: cover property (@(posedge ref_clk) disable iff (reset)
        ev[0] && ctl_q[0].edge_sel == acc_pkg::EDGE_RISING);
    c_irq: cover property (@(posedge ref_clk) disable iff (reset) irq);
    c_clr: cover property (@(posedge ref_clk) disable iff (reset)
        w1c_status && |flag_q);
endmodule

// *** tb/acc_top_tb.sv ***
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module acc_top_tb;
    logic                   ref_clk;
    logic                   reset;
    logic [acc_pkg::AW-1:0] reg_addr;
    logic [acc_pkg::DW-1:0] reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [acc_pkg::DW-1:0] reg_rdata;
    logic [2:0]             cmp_raw;
    logic [2:0]             vector_ack;
    logic [2:0]             cmp_analog_on;
    logic [8:0]             cmp_neg_sel;
    logic [8:0]             cmp_hyst_sel;
    logic [2:0]             cmp_pin_out;
    logic [2:0]             cmp_pin_oe_n;
    logic                   cmp3_alt_out;
    logic                   cmp3_alt_oe_n;
    logic                   capture_in;
    logic [2:0]             cmp_irq_req;
    logic                   irq;
    int                     failures;
    int                     tests_run;
    logic [8:0]             exp_sel;
    logic [7:0]             res;
    logic [7:0]             flg;
    // Per sensitivity code: does a rising or a falling output set the flag
    logic [3:0]             rise_tab = 4'b1001;
    logic [3:0]             fall_tab = 4'b0101;

    acc_top acc_top_inst (
        .ref_clk       (ref_clk),
        .reset         (reset),
        .reg_addr      (reg_addr),
        .reg_wdata     (reg_wdata),
        .reg_wr        (reg_wr),
        .reg_rd        (reg_rd),
        .reg_rdata     (reg_rdata),
        .cmp_raw       (cmp_raw),
        .vector_ack    (vector_ack),
        .cmp_analog_on (cmp_analog_on),
        .cmp_neg_sel   (cmp_neg_sel),
        .cmp_hyst_sel  (cmp_hyst_sel),
        .cmp_pin_out   (cmp_pin_out),
        .cmp_pin_oe_n  (cmp_pin_oe_n),
        .cmp3_alt_out  (cmp3_alt_out),
        .cmp3_alt_oe_n (cmp3_alt_oe_n),
        .capture_in    (capture_in),
        .cmp_irq_req   (cmp_irq_req),
        .irq           (irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Write ends just past the sampling edge so outputs have settled
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk({1'b0, reg_rdata}, {1'b0, exp});
    endtask

    // Long enough for two sync stages, the detector and the flag
    task automatic settle();
        repeat (6) @(posedge ref_clk);
        #1;
    endtask

    task automatic drive_raw(input int i, input logic v);
        @(posedge ref_clk);
        cmp_raw[i] <= v;
        settle();
    endtask

    task automatic pulse_ack();
        @(posedge ref_clk);
        vector_ack <= 3'b001;
        @(posedge ref_clk);
        vector_ack <= 3'b000;
        #1;
    endtask

    initial begin
        #400000;
        failures++;
        stop_test();
    end

    initial begin
        reset = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cmp_raw = 3'b000;
        vector_ack = 3'b000;
        failures = 0;
        tests_run = 0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        chk(9'(cmp_pin_oe_n), 9'h007);
        chk(9'(cmp3_alt_oe_n), 9'h001);
        chk(9'({cmp_analog_on, irq}), 9'h000);
        for (int a = 0; a < 16; a++) rchk(4'(a), 8'h00);
        wr(acc_pkg::ADDR_CTRL1, 8'hFF);
        rchk(acc_pkg::ADDR_CTRL1, 8'hF7);
        wr(acc_pkg::ADDR_CTRL3, 8'hFF);
        rchk(acc_pkg::ADDR_CTRL3, 8'hFF);
        chk(9'(cmp3_alt_oe_n), 9'h000);
        wr(acc_pkg::ADDR_ECTRL2, 8'hFF);
        rchk(acc_pkg::ADDR_ECTRL2, 8'h3F);
        chk(9'(cmp_pin_oe_n), 9'h005);
        wr(4'hF, 8'hFF);
        rchk(4'hF, 8'h00);
        for (int c = 0; c < 8; c++) begin
            for (int i = 0; i < 3; i++) begin
                wr(acc_pkg::ADDR_CTRL1 + 4'(i), {5'b10000, 3'(c + i)});
                wr(acc_pkg::ADDR_ECTRL1 + 4'(i), {5'b00000, 3'(c + i)});
                exp_sel[3*i +: 3] = 3'(c + i);
            end
            chk(cmp_neg_sel, exp_sel);
            chk(cmp_hyst_sel, exp_sel);
            chk(9'(cmp_analog_on), 9'h007);
        end
        for (int i = 0; i < 3; i++) begin
            res = 8'h02 << i;
            flg = 8'h20 << i;
            wr(acc_pkg::ADDR_ECTRL1 + 4'(i), 8'h00);
            for (int m = 0; m < 4; m++) begin
                wr(acc_pkg::ADDR_CTRL1 + 4'(i), {2'b11, 2'(m), 4'h0});
                settle();
                wr(acc_pkg::ADDR_STATUS, 8'hE0);
                drive_raw(i, 1'b1);
                rchk(acc_pkg::ADDR_STATUS, rise_tab[m] ? res | flg : res);
                wr(acc_pkg::ADDR_STATUS, flg);
                settle();
                rchk(acc_pkg::ADDR_STATUS, res);
                drive_raw(i, 1'b0);
                rchk(acc_pkg::ADDR_STATUS, fall_tab[m] ? flg : 8'h00);
                wr(acc_pkg::ADDR_STATUS, 8'hE0);
            end
            wr(acc_pkg::ADDR_CTRL1 + 4'(i), 8'h00);
            drive_raw(i, 1'b1);
            rchk(acc_pkg::ADDR_STATUS, 8'h00);
            drive_raw(i, 1'b0);
            rchk(acc_pkg::ADDR_STATUS, 8'h00);
        end
        // Interrupt path on comparator 1, rising edge
        wr(acc_pkg::ADDR_CTRL1, 8'hF0);
        wr(acc_pkg::ADDR_IRQ_EN, 8'h01);
        rchk(acc_pkg::ADDR_IRQ_EN, 8'h01);
        drive_raw(0, 1'b1);
        chk(9'({cmp_irq_req, irq}), 9'h003);
        wr(acc_pkg::ADDR_IRQ_EN, 8'h00);
        chk(9'({cmp_irq_req, irq}), 9'h002);
        wr(acc_pkg::ADDR_IRQ_EN, 8'h01);
        wr(acc_pkg::ADDR_IRQ_CLR, 8'h01);
        chk(9'({cmp_irq_req, irq}), 9'h000);
        rchk(acc_pkg::ADDR_IRQ_CLR, 8'h00);
        drive_raw(0, 1'b0);
        drive_raw(0, 1'b1);
        chk(9'(irq), 9'h001);
        pulse_ack();
        rchk(acc_pkg::ADDR_STATUS, 8'h02);
        wr(acc_pkg::ADDR_CTRL1, 8'hB0);
        drive_raw(0, 1'b0);
        drive_raw(0, 1'b1);
        chk(9'(cmp_irq_req), 9'h000);
        pulse_ack();
        rchk(acc_pkg::ADDR_STATUS, 8'h22);
        // Output shaping while the result is high; pin output lags a cycle
        wr(acc_pkg::ADDR_ECTRL1, 8'h30);
        settle();
        chk(9'({cmp_pin_out[0], cmp_pin_oe_n[0]}), 9'h000);
        rchk(acc_pkg::ADDR_STATUS, 8'h22);
        chk(9'(capture_in), 9'h000);
        wr(acc_pkg::ADDR_ECTRL1, 8'h08);
        settle();
        chk(9'({cmp_pin_out[0], cmp_pin_oe_n[0]}), 9'h003);
        chk(9'(capture_in), 9'h001);
        // Pin blocked and routing off while the output stays high
        wr(acc_pkg::ADDR_ECTRL1, 8'h00);
        chk(9'({capture_in, cmp_pin_oe_n[0]}), 9'h001);
        wr(acc_pkg::ADDR_CTRL3, 8'h88);
        wr(acc_pkg::ADDR_ECTRL3, 8'h20);
        drive_raw(2, 1'b1);
        chk(9'({cmp_pin_out[2], cmp3_alt_out}), 9'h000);
        drive_raw(2, 1'b0);
        chk(9'({cmp_pin_out[2], cmp3_alt_out}), 9'h003);
        stop_test();
    end
endmodule
